// [hdl/ddrc_pkg.sv]
// Shared constants and types for the DDR command controller
package ddrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and divider
    localparam int T_CLK_NS = 20;
    localparam int CK_HALF = 2;
    localparam int T_CK_NS = 2 * CK_HALF * T_CLK_NS;
    localparam logic [1:0] PHASE_LAST = 2'(CK_HALF - 1);

    ////////////////////////////////////////////////////////////////////////
    // Device timing in ns, and in whole CK cycles rounded up
    localparam int T_RP_NS = 15;
    localparam int T_RCD_NS = 15;
    localparam int T_RFC_NS = 70;
    localparam int T_MRD_NS = 10;
    localparam int T_WR_NS = 15;
    localparam int BURST_LEN = 4;
    localparam int TW = 8;
    localparam logic [TW-1:0] RP_CK = TW'((T_RP_NS + T_CK_NS - 1) / T_CK_NS);
    localparam logic [TW-1:0] RCD_CK = TW'((T_RCD_NS + T_CK_NS - 1) / T_CK_NS);
    localparam logic [TW-1:0] RFC_CK = TW'((T_RFC_NS + T_CK_NS - 1) / T_CK_NS);
    localparam logic [TW-1:0] MRD_CK = TW'((T_MRD_NS + T_CK_NS - 1) / T_CK_NS);
    localparam logic [TW-1:0] WR_CK = TW'((T_WR_NS + T_CK_NS - 1) / T_CK_NS);
    localparam logic [TW-1:0] BURST_CK = TW'(BURST_LEN / 2);
    localparam logic [TW-1:0] WRAP_CK = TW'(BURST_LEN / 2 + 1) + WR_CK;
    localparam logic [TW-1:0] TMR_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Widths and fields
    localparam int NBANK = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;

    ////////////////////////////////////////////////////////////////////////
    // RAS#, CAS#, WE# codes with CS# low
    localparam logic [2:0] RCW_ACT = 3'h3;
    localparam logic [2:0] RCW_RD = 3'h5;
    localparam logic [2:0] RCW_WR = 3'h4;
    localparam logic [2:0] RCW_PRE = 3'h2;
    localparam logic [2:0] RCW_BST = 3'h6;
    localparam logic [2:0] RCW_REF = 3'h1;
    localparam logic [2:0] RCW_LMR = 3'h0;
    localparam logic [2:0] RCW_NOP = 3'h7;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_REF, CMD_LMR} ddrc_cmd_e;
    typedef enum logic [2:0] {B_IDLE, B_ACTIVATING, B_ACTIVE, B_READ, B_WRITE, B_RD_AP, B_WR_AP, B_PRECHARGING}
        ddrc_bank_e;
    typedef enum logic [1:0] {G_NORMAL, G_REFRESH, G_MODE, G_PREALL} ddrc_glob_e;

endpackage

// [hdl/ddrc_bank.sv]
// State and timer of one DDR bank as seen from the controller
module ddrc_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic issue,
    input ddrc_pkg::ddrc_cmd_e cmd,
    input wire logic ap,
    input wire logic bst,
    input wire logic cut,
    input wire logic pre_all,
    output ddrc_pkg::ddrc_bank_e state
);

    typedef struct packed {
        ddrc_pkg::ddrc_bank_e st;
        logic [ddrc_pkg::TW-1:0] tmr;
    } ddrc_bank_s;

    ddrc_bank_s q;
    ddrc_bank_s d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        if (issue) begin
            case (cmd)
                ddrc_pkg::CMD_ACT: begin
                    d.st = ddrc_pkg::B_ACTIVATING;
                    d.tmr = ddrc_pkg::RCD_CK;
                end
                ddrc_pkg::CMD_RD: begin
                    d.st = ap ? ddrc_pkg::B_RD_AP : ddrc_pkg::B_READ;
                    d.tmr = ddrc_pkg::BURST_CK;
                end
                ddrc_pkg::CMD_WR: begin
                    d.st = ap ? ddrc_pkg::B_WR_AP : ddrc_pkg::B_WRITE;
                    d.tmr = ap ? ddrc_pkg::WRAP_CK : ddrc_pkg::BURST_CK;
                end
                ddrc_pkg::CMD_PRE: begin
                    d.st = ddrc_pkg::B_PRECHARGING;
                    d.tmr = ddrc_pkg::RP_CK;
                end
                default: begin
                end
            endcase
        end else if (pre_all) begin
            // The controller holds the whole device for tRP after this
            d.st = ddrc_pkg::B_IDLE;
            d.tmr = ddrc_pkg::TMR_ZERO;
        end else if (bst && q.st == ddrc_pkg::B_READ) begin
            d.st = ddrc_pkg::B_ACTIVE;
        end else if (cut && (q.st == ddrc_pkg::B_READ || q.st == ddrc_pkg::B_WRITE)) begin
            d.st = ddrc_pkg::B_ACTIVE;
        end else if (tick) begin
            if (q.tmr != ddrc_pkg::TMR_ZERO) begin
                d.tmr = q.tmr - 8'h01;
            end else begin
                case (q.st)
                    ddrc_pkg::B_ACTIVATING: d.st = ddrc_pkg::B_ACTIVE;
                    ddrc_pkg::B_READ: d.st = ddrc_pkg::B_ACTIVE;
                    ddrc_pkg::B_WRITE: d.st = ddrc_pkg::B_ACTIVE;
                    ddrc_pkg::B_RD_AP, ddrc_pkg::B_WR_AP: begin
                        d.st = ddrc_pkg::B_PRECHARGING;
                        d.tmr = ddrc_pkg::RP_CK;
                    end
                    ddrc_pkg::B_PRECHARGING: d.st = ddrc_pkg::B_IDLE;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{st: ddrc_pkg::B_IDLE, tmr: 8'h00};
        end else begin
            q <= d;
        end
    end

    assign state = q.st;

endmodule

// [hdl/ddrc_host.sv]
// DDR command controller: CK divider, bank tracking, legality check, pin drive
//
// Function
// - Commands only while clock enable held high
// - Busy bank gets no command
// - After refresh only NOP until tRFC
// - After mode load only NOP until tMRD
// - After precharge all only NOP until tRP
// - Refresh, mode load need all banks idle
// - Multi-bank precharge needs every bank valid
// - Write after read only when burst ended
// - Read interrupting write masks write data
// - Command encoding on CS, RAS, CAS, WE
// - Idle bank n leaves bank m free
// - Busy bank n allows others' legal commands
// - Other-bank commands avoid data contention
// - A10 high on access selects auto precharge
module ddrc_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input ddrc_pkg::ddrc_cmd_e req_cmd,
    input wire logic [ddrc_pkg::BA_W-1:0] req_bank,
    input wire logic [ddrc_pkg::ADDR_W-1:0] req_addr,
    output logic req_ready,
    output logic err,
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ddrc_pkg::BA_W-1:0] ba,
    output logic [ddrc_pkg::ADDR_W-1:0] addr,
    output logic dm
);

    typedef struct packed {
        logic [1:0] phase;
        logic ck;
        logic cke;
        logic cs_n;
        logic [2:0] rcw;
        logic [ddrc_pkg::BA_W-1:0] ba;
        logic [ddrc_pkg::ADDR_W-1:0] addr;
        logic dm;
        logic [ddrc_pkg::TW-1:0] dm_cnt;
        logic err;
        ddrc_pkg::ddrc_glob_e gst;
        logic [ddrc_pkg::TW-1:0] gtmr;
        logic [ddrc_pkg::BA_W-1:0] last_rd;
    } ddrc_host_s;

    ddrc_host_s q;
    ddrc_host_s d;

    ddrc_pkg::ddrc_bank_e bank_st [ddrc_pkg::NBANK];
    logic [ddrc_pkg::NBANK-1:0] bank_issue;
    logic [ddrc_pkg::NBANK-1:0] bank_bst;

    logic toggle;
    logic rise_en;
    logic fall_en;
    logic take;
    logic legal;
    logic ok;
    logic ap;
    logic per_bank;
    logic pre_all;
    logic cut;
    logic any_read;
    logic any_write;
    logic any_wr_ap;
    logic all_idle;
    logic pre_all_ok;
    logic row_open;
    ddrc_pkg::ddrc_bank_e sel;

    ////////////////////////////////////////////////////////////////////////
    // CK divider: commands change on CK fall, the device takes them on rise
    always_comb begin
        toggle = (q.phase == ddrc_pkg::PHASE_LAST);
        rise_en = toggle && !q.ck;
        fall_en = toggle && q.ck;
    end

    assign req_ready = fall_en;

    ////////////////////////////////////////////////////////////////////////
    // Summary of bank states
    always_comb begin
        any_read = 1'b0;
        any_write = 1'b0;
        any_wr_ap = 1'b0;
        all_idle = 1'b1;
        pre_all_ok = 1'b1;
        for (int i = 0; i < ddrc_pkg::NBANK; i++) begin
            if (bank_st[i] == ddrc_pkg::B_READ || bank_st[i] == ddrc_pkg::B_RD_AP) begin
                any_read = 1'b1;
            end
            if (bank_st[i] == ddrc_pkg::B_WRITE) begin
                any_write = 1'b1;
            end
            if (bank_st[i] == ddrc_pkg::B_WR_AP) begin
                any_wr_ap = 1'b1;
            end
            if (bank_st[i] != ddrc_pkg::B_IDLE) begin
                all_idle = 1'b0;
            end
            case (bank_st[i])
                ddrc_pkg::B_IDLE, ddrc_pkg::B_ACTIVE, ddrc_pkg::B_READ, ddrc_pkg::B_WRITE: begin
                end
                default: pre_all_ok = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Legality of the offered command against the bank tables
    always_comb begin
        sel = bank_st[req_bank];
        ap = req_addr[ddrc_pkg::AP_BIT];
        row_open = (sel == ddrc_pkg::B_ACTIVE) || (sel == ddrc_pkg::B_READ) || (sel == ddrc_pkg::B_WRITE);
        legal = 1'b0;
        // The target bank's state matters, plus other banks' reads (for WR), write-ap bursts (for RD), and all banks for REF, LMR, precharge all
        case (req_cmd)
            ddrc_pkg::CMD_NOP: legal = 1'b1;
            ddrc_pkg::CMD_ACT: legal = (sel == ddrc_pkg::B_IDLE);
            ddrc_pkg::CMD_RD: legal = row_open && !any_wr_ap;
            ddrc_pkg::CMD_WR: legal = row_open && !any_read;
            ddrc_pkg::CMD_PRE: begin
                if (ap) begin
                    legal = pre_all_ok;
                end else begin
                    legal = row_open;
                end
            end
            ddrc_pkg::CMD_BST: legal = (bank_st[q.last_rd] == ddrc_pkg::B_READ);
            ddrc_pkg::CMD_REF: legal = all_idle;
            ddrc_pkg::CMD_LMR: legal = all_idle;
            default: legal = 1'b0;
        endcase
        if (q.gst != ddrc_pkg::G_NORMAL) begin
            legal = (req_cmd == ddrc_pkg::CMD_NOP);
        end
        if (!q.cke) begin
            legal = (req_cmd == ddrc_pkg::CMD_NOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Issue decision and per-bank strobes
    always_comb begin
        take = fall_en && req_valid;
        ok = take && legal;
        per_bank = (req_cmd == ddrc_pkg::CMD_ACT) || (req_cmd == ddrc_pkg::CMD_RD) ||
                   (req_cmd == ddrc_pkg::CMD_WR) || (req_cmd == ddrc_pkg::CMD_PRE && !ap);
        pre_all = ok && (req_cmd == ddrc_pkg::CMD_PRE) && ap;
        cut = ok && ((req_cmd == ddrc_pkg::CMD_RD) || (req_cmd == ddrc_pkg::CMD_WR));
    end

    genvar gi;
    generate
        for (gi = 0; gi < ddrc_pkg::NBANK; gi++) begin : g_bank
            assign bank_issue[gi] = ok && per_bank && (req_bank == ddrc_pkg::BA_W'(gi));
            assign bank_bst[gi] = ok && (req_cmd == ddrc_pkg::CMD_BST) && (q.last_rd == ddrc_pkg::BA_W'(gi));
            ddrc_bank u_bank (
                .clk(clk),
                .rst(rst),
                .tick(rise_en),
                .issue(bank_issue[gi]),
                .cmd(req_cmd),
                .ap(ap),
                .bst(bank_bst[gi]),
                .cut(cut),
                .pre_all(pre_all),
                .state(bank_st[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state of divider, pins, device-wide timer and data mask
    always_comb begin
        d = q;
        d.err = 1'b0;
        d.cke = 1'b1;
        if (toggle) begin
            d.phase = 2'h0;
            d.ck = !q.ck;
        end else begin
            d.phase = q.phase + 2'h1;
        end

        // Pins
        if (fall_en) begin
            d.cs_n = 1'b1;
            d.rcw = ddrc_pkg::RCW_NOP;
            if (ok) begin
                d.cs_n = 1'b0;
                d.ba = req_bank;
                d.addr = req_addr;
                case (req_cmd)
                    ddrc_pkg::CMD_ACT: d.rcw = ddrc_pkg::RCW_ACT;
                    ddrc_pkg::CMD_RD: d.rcw = ddrc_pkg::RCW_RD;
                    ddrc_pkg::CMD_WR: d.rcw = ddrc_pkg::RCW_WR;
                    ddrc_pkg::CMD_PRE: d.rcw = ddrc_pkg::RCW_PRE;
                    ddrc_pkg::CMD_BST: d.rcw = ddrc_pkg::RCW_BST;
                    ddrc_pkg::CMD_REF: d.rcw = ddrc_pkg::RCW_REF;
                    ddrc_pkg::CMD_LMR: d.rcw = ddrc_pkg::RCW_LMR;
                    default: d.rcw = ddrc_pkg::RCW_NOP;
                endcase
            end
            if (take && !legal) begin
                d.err = 1'b1;
            end
        end

        // Latest read burst owner
        if (ok && req_cmd == ddrc_pkg::CMD_RD) begin
            d.last_rd = req_bank;
        end

        // Device-wide busy periods
        if (ok && req_cmd == ddrc_pkg::CMD_REF) begin
            d.gst = ddrc_pkg::G_REFRESH;
            d.gtmr = ddrc_pkg::RFC_CK;
        end else if (ok && req_cmd == ddrc_pkg::CMD_LMR) begin
            d.gst = ddrc_pkg::G_MODE;
            d.gtmr = ddrc_pkg::MRD_CK;
        end else if (pre_all) begin
            d.gst = ddrc_pkg::G_PREALL;
            d.gtmr = ddrc_pkg::RP_CK;
        end else if (rise_en && q.gst != ddrc_pkg::G_NORMAL) begin
            if (q.gtmr == ddrc_pkg::TMR_ZERO) begin
                d.gst = ddrc_pkg::G_NORMAL;
            end else begin
                d.gtmr = q.gtmr - 8'h01;
            end
        end

        // Mask the remainder of a write burst cut by a read
        if (ok && req_cmd == ddrc_pkg::CMD_RD && any_write) begin
            d.dm_cnt = ddrc_pkg::BURST_CK;
        end else if (rise_en && q.dm_cnt != ddrc_pkg::TMR_ZERO) begin
            d.dm_cnt = q.dm_cnt - 8'h01;
        end
        d.dm = (d.dm_cnt != ddrc_pkg::TMR_ZERO);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            q.phase <= 2'h0;
            q.ck <= 1'b0;
            q.cke <= 1'b1;
            q.cs_n <= 1'b1;
            q.rcw <= 3'h7;
            q.ba <= 2'h0;
            q.addr <= 13'h0000;
            q.dm <= 1'b0;
            q.dm_cnt <= 8'h00;
            q.err <= 1'b0;
            q.gst <= ddrc_pkg::G_NORMAL;
            q.gtmr <= 8'h00;
            q.last_rd <= 2'h0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        ck = q.ck;
        cke = q.cke;
        cs_n = q.cs_n;
        ras_n = q.rcw[2];
        cas_n = q.rcw[1];
        we_n = q.rcw[0];
        ba = q.ba;
        addr = q.addr;
        dm = q.dm;
        err = q.err;
    end

endmodule

// [verification/ddrc_host_properties.sv]
// Checker of request handshake and pin timing for the DDR command controller
module ddrc_host_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input ddrc_pkg::ddrc_cmd_e req_cmd,
    input wire logic [ddrc_pkg::BA_W-1:0] req_bank,
    input wire logic [ddrc_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_ready,
    input wire logic err,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddrc_pkg::BA_W-1:0] ba,
    input wire logic [ddrc_pkg::ADDR_W-1:0] addr,
    input wire logic dm
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic take = req_ready && req_valid;
    function automatic logic [2:0] rcw(ddrc_pkg::ddrc_cmd_e c);
        logic [2:0] t [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h6, 3'h1, 3'h0};
        return t[c];
    endfunction
    ////////////////////////////////////////////////////////////////////////
    a_cke_high: assert property (cke) else $error("cke dropped");
    a_ready_cadence: assert property (req_ready |=> !req_ready [*3] ##1 req_ready) else $error("ready cadence");
    a_ck_falls: assert property (req_ready |-> ck ##1 !ck) else $error("ck phase");
    a_pins_hold: assert property (!$past(req_ready) |-> $stable({cs_n, ras_n, cas_n, we_n, ba, addr}))
        else $error("pins moved");
    a_idle_deselect: assert property (req_ready && !req_valid |=> cs_n) else $error("no deselect");
    a_cmd_code: assert property (take |=> cs_n || {ras_n, cas_n, we_n} == rcw($past(req_cmd)))
        else $error("wrong command code");
    a_addr_bank: assert property (take && req_cmd inside {ddrc_pkg::CMD_ACT, ddrc_pkg::CMD_RD, ddrc_pkg::CMD_WR}
        |=> cs_n || (ba == $past(req_bank) && addr == $past(req_addr))) else $error("wrong address");
    a_err_drop: assert property (err |-> cs_n ##1 !err) else $error("err shape");
    a_busy_bank: assert property ((take && req_cmd == ddrc_pkg::CMD_ACT) ##1 !cs_n ##3 (take
        && req_bank == $past(req_bank, 4) && !(req_cmd inside {ddrc_pkg::CMD_NOP, ddrc_pkg::CMD_BST}))
        |=> cs_n) else $error("activating bank accepted a command");
    a_global_busy: assert property ((take && (req_cmd inside {ddrc_pkg::CMD_REF, ddrc_pkg::CMD_LMR}
        || (req_cmd == ddrc_pkg::CMD_PRE && req_addr[ddrc_pkg::AP_BIT]))) ##1 !cs_n ##3
        (take && req_cmd != ddrc_pkg::CMD_NOP) |=> cs_n) else $error("command while device busy");
    a_dm_read: assert property ($rose(dm) |-> !cs_n && {ras_n, cas_n, we_n} == 3'h5) else $error("dm without read");
endmodule

bind ddrc_host ddrc_host_properties i_props (.clk(clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready), .err(err), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm));

// [verification/ddrc_dev_model.sv]
// Behavioural DDR device that tracks bank busy periods and counts illegal commands
module ddrc_dev_model (
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddrc_pkg::BA_W-1:0] ba,
    input wire logic [ddrc_pkg::ADDR_W-1:0] addr,
    output int bad_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy [4] = '{default: 0};
    bit open [4] = '{default: 0};
    int gbusy = 0;
    initial bad_cnt = 0;
    always @(posedge ck) begin
        logic [2:0] c;
        bit sel;
        c = {ras_n, cas_n, we_n};
        sel = cke && !cs_n && c != 3'h7;
        if (sel) begin
            if (gbusy > 0) bad_cnt++;
            if ((c inside {3'h3, 3'h5, 3'h4} || (c == 3'h2 && !addr[10])) && busy[ba] > 0) bad_cnt++;
            if (c inside {3'h1, 3'h0} && (open.or() || busy.sum() > 0)) bad_cnt++;
        end
        foreach (busy[i]) if (busy[i] > 0) busy[i]--;
        if (gbusy > 0) gbusy--;
        if (sel) begin
            case (c)
                3'h3: begin busy[ba] = 1; open[ba] = 1; end
                3'h5, 3'h4: if (addr[10]) begin busy[ba] = 2; open[ba] = 0; end
                3'h2: if (addr[10]) begin gbusy = 1; open = '{default: 0}; end else begin busy[ba] = 1; open[ba] = 0; end
                3'h1, 3'h0: gbusy = 1;
                default: ;
            endcase
        end
    end
endmodule

// [verification/ddrc_host_tb_top.sv]
// Self-checking bench for the DDR command controller with a reference bank model
module ddrc_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NOP = 0, ACT = 1, RD = 2, WR = 3, PRE = 4, BST = 5, REF = 6, LMR = 7;
    localparam string KEYS = "NARWPTFL";
    localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h6, 3'h1, 3'h0};
    localparam string SCN [3] = '{"Ab Ab Nb Rb Wb Tb Nb Nb Wb Rb Nb Nb Nb Pb Rb Nb Nb Ab Nb Nb",
        "Fb Ao PB Nb Nb PB Ab Nb Nb Fb Ao Nb Nb Lb Ab Nb Nb",
        "Ab Ao Nb Nb WB Ro Wo Nb Nb Nb Nb Nb Nb Nb Ab Nb Nb RO Ro Wb Rb Nb Nb Nb Nb Nb Nb PB Nb Nb"};
    logic clk = 0, rst = 1, req_valid = 0;
    ddrc_pkg::ddrc_cmd_e req_cmd = ddrc_pkg::CMD_NOP;
    logic [ddrc_pkg::BA_W-1:0] req_bank = '0, ba;
    logic [ddrc_pkg::ADDR_W-1:0] req_addr = '0, addr;
    logic req_ready, err, ck, cke, cs_n, ras_n, cas_n, we_n, dm;
    int n_errors = 0, compares = 0, bad_cnt, gtm = 0, last = 0, dmc = 0;
    int st [4] = '{default: 0}, tm [4] = '{default: 0};
    ddrc_host i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
        .req_addr(req_addr), .req_ready(req_ready), .err(err), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm));
    ddrc_dev_model i_dev (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .bad_cnt(bad_cnt));
    initial begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [14:0] seen, logic [14:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bank states: 0 idle, 1 activating, 2 active, 3 read, 4 write, 5 read ap, 6 write ap, 7 precharging
    function automatic bit legal(int c, int b, bit a);
        bit idle = 1, wrap = 0, rd = 0, pa = 1;
        foreach (st[i]) begin
            idle &= st[i] == 0;
            wrap |= st[i] == 6;
            rd |= st[i] inside {3, 5};
            pa &= st[i] inside {0, 2, 3, 4};
        end
        if (gtm > 0) return c == NOP;
        case (c)
            ACT: return st[b] == 0;
            RD: return st[b] inside {2, 3, 4} && !wrap;
            WR: return st[b] inside {2, 3, 4} && !rd;
            PRE: return a ? pa : st[b] inside {2, 3, 4};
            BST: return st[last] == 3;
            REF, LMR: return idle;
            default: return 1;
        endcase
    endfunction
    task automatic op(int c, int b, bit a, bit v = 1);
        bit ok, dmx = 0;
        logic e = 0, d = 0;
        int w = 0;
        logic [ddrc_pkg::ADDR_W-1:0] ad;
        ad = 13'($urandom);
        ad[10] = a;
        req_valid = v;
        req_cmd = ddrc_pkg::ddrc_cmd_e'(c);
        req_bank = 2'(b);
        req_addr = ad;
        while (req_ready !== 1'b1 && w++ < 8) @(negedge clk);
        check("req_ready", 15'(req_ready), 15'h1);
        @(posedge clk);
        foreach (tm[i]) begin
            if (tm[i] > 0 && --tm[i] == 0) begin
                if (st[i] inside {5, 6}) begin
                    st[i] = 7;
                    tm[i] = 2;
                end else begin
                    st[i] = st[i] inside {1, 3, 4} ? 2 : 0;
                end
            end
        end
        if (gtm > 0) gtm--;
        ok = legal(c, b, a);
        if (ok && c inside {RD, WR}) begin
            foreach (st[i]) begin
                if (st[i] inside {3, 4}) begin
                    dmx |= st[i] == 4 && c == RD;
                    st[i] = 2;
                    tm[i] = 0;
                end
            end
            if (c == RD) last = b;
        end
        if (ok) begin
            case (c)
                RD, WR: begin st[b] = (a ? 5 : 3) + (c == WR); tm[b] = (a && c == WR) ? 5 : 3; end
                ACT: begin st[b] = 1; tm[b] = 2; end
                PRE: if (a) begin st = '{default: 0}; tm = '{default: 0}; gtm = 2; end else begin st[b] = 7; tm[b] = 2; end
                REF, LMR: gtm = 2;
                BST: begin st[last] = 2; tm[last] = 0; end
                default: ;
            endcase
        end
        if (dmx) dmc = 3;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            if (k == 0) begin
                check("cs_n", 15'(cs_n), 15'(!(ok && v)));
                if (ok && v) check("code", 15'({ras_n, cas_n, we_n}), 15'(ENC[c]));
                if (ok && v && c inside {ACT, RD, WR, LMR}) check("ba_addr", 15'({ba, addr}), 15'({2'(b), ad}));
            end
            e = e | err;
            d = d | dm;
        end
        check("err", 15'(e), 15'(!ok));
        if (dmc == 3 || dmc == 0) check("dm", 15'(d), 15'(dmc == 3));
        if (dmc > 0) dmc--;
    endtask
    task automatic run(string s, int b, int o);
        int c;
        for (int i = 0; i < s.len(); i += 3) begin
            c = 0;
            for (int j = 0; j < 8; j++) if (s[i] == KEYS[j]) c = j;
            op(c, (s[i+1] == "o" || s[i+1] == "O") ? o : b, s[i+1] < "a");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(71489));
        repeat (12) @(negedge clk);
        rst = 0;
        check("reset", 15'({cke, cs_n, dm}), 15'h6);
        for (int t = 0; t < 9; t++) begin
            int b;
            b = $urandom % 4;
            run(SCN[t % 3], b, (b + 1) % 4);
            // One CK with no request offered: pins must show deselect
            op(NOP, 0, 0, 0);
            $display("Test %0d finished", t);
        end
        req_valid = 0;
        check("device", 15'(bad_cnt), 15'h0);
        test_done();
    end
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule
